// file: bench/umps_modem.sv
`timescale 1ns/1ns
`default_nettype none
module umps_modem (
	input wire logic [1:0] rts_n,
	input wire logic [1:0] rts_oe,
	input wire logic [1:0] dtr_n,
	input wire logic [1:0] dtr_oe,
	input wire logic [1:0] tx,
	input wire logic [1:0] tx_oe,
	input wire logic [3:0] pull_up,
	input wire logic [3:0] state,
	output logic [1:0] rts_pin,
	output logic [1:0] dtr_pin,
	output logic [1:0] tx_pin,
	output logic [1:0] cts_n,
	output logic [1:0] dsr_n,
	output logic [1:0] dcd_n,
	output logic [1:0] ri_n
);
	// Released pins fall to the pull-down unless fitted with a pull-up
	assign rts_pin = rts_oe[0] ? rts_n : {1'b0, pull_up[0]};
	assign dtr_pin = dtr_oe[0] ? dtr_n : {1'b0, pull_up[1]};
	assign tx_pin = tx_oe[0] ? tx : pull_up[3:2];
	assign cts_n = {2{~state[0]}};
	assign dsr_n = {2{~state[1]}};
	assign ri_n = {2{~state[2]}};
	assign dcd_n = {2{~state[3]}};
endmodule
`default_nettype wire

// file: bench/umps_props.sv
`timescale 1ns/1ns
`default_nettype none
module umps_props (
	input wire logic clk,
	input wire logic srst,
	input wire logic [1:0] clear_to_send_in_n,
	input wire logic [1:0] uart_rts,
	input wire logic [1:0] uart_dtr,
	input wire logic [1:0] uart_tx,
	input wire logic [1:0] request_send_out_n,
	input wire logic [1:0] request_send_oe,
	input wire logic [1:0] terminal_ready_out_n,
	input wire logic [1:0] serial_tx,
	input wire logic [1:0] serial_tx_oe,
	input wire logic [7:0] hs_status_a,
	input wire logic wake_event,
	input wire logic wake_clear,
	input wire logic rx_byte_valid,
	input wire logic rx_byte_ready,
	input wire logic rx_out_valid,
	input wire logic rx_out_ready,
	input wire logic [7:0] rx_out_byte,
	input wire logic [7:0] global_option_reg,
	input wire logic [7:0] global_option_reg_b,
	input wire logic [7:0] cfg_port_addr
);
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Shadow fill level, kept apart from the design
	always_comb begin
		next_cnt = cnt + 2'(rx_byte_valid && rx_byte_ready) - 2'(rx_out_valid && rx_out_ready);
	end
	always_ff @(posedge clk) begin
		cnt <= srst ? 2'h0 : next_cnt;
	end
	AST_CTS: assert property ($fell(clear_to_send_in_n[0]) |-> ##[1:4] hs_status_a[4])
		else $error("clear to send not seen in status");
	AST_RTS: assert property (request_send_oe[0] |-> request_send_out_n == ~$past(uart_rts))
		else $error("request to send pin wrong");
	AST_DTR: assert property (request_send_oe[0] |-> terminal_ready_out_n == ~$past(uart_dtr))
		else $error("terminal ready pin wrong");
	AST_TX: assert property (serial_tx_oe[1] |-> serial_tx == $past(uart_tx))
		else $error("serial out wrong");
	AST_CFG: assert property (request_send_oe[0] |-> cfg_port_addr == (global_option_reg_b[6] ?
		umps_pkg::CFG_PORT_HIGH : umps_pkg::CFG_PORT_LOW))
		else $error("config port address wrong");
	AST_HOLD: assert property ($past(request_send_oe[0]) |-> $stable(global_option_reg)
		&& $stable(global_option_reg_b))
		else $error("strap value moved");
	AST_FILL: assert property (rx_byte_ready == (cnt != 2'h2) && rx_out_valid == (cnt != 2'h0))
		else $error("buffer flags wrong");
	AST_STALL: assert property (rx_out_valid && !rx_out_ready |=> rx_out_valid && $stable(rx_out_byte))
		else $error("held byte lost");
	AST_WAKE: assert property (wake_event && !wake_clear |=> wake_event)
		else $error("wake dropped");
	COV_FULL: cover property (rx_byte_valid && !rx_byte_ready);
	COV_WAKE: cover property ($rose(wake_event));
	COV_STRAP: cover property ($rose(request_send_oe[0]) && global_option_reg_b[6]);
endmodule
bind umps_top umps_props i_umps_props (.*);
`default_nettype wire

// file: bench/umps_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module umps_top_bench;
	logic clk = 0, srst = 1, ir_mode = 0, infrared_rx = 1, uart_ir_tx = 1, gp3_bit7_out = 0;
	logic consumer_ir_rx_n = 1, wake_enable = 0, wake_clear = 0, rx_byte_valid = 0, rx_out_ready = 0;
	logic [1:0] serial_rx = 2'h3, uart_rts = 0, uart_dtr = 0, uart_tx = 0;
	logic [3:0] pull_up = 0, state = 0;
	logic [7:0] rx_byte = 0;
	logic [1:0] cts_n, dsr_n, dcd_n, ri_n, rts_pin, dtr_pin, tx_pin, rts_n, rts_oe, dtr_n, dtr_oe;
	logic [1:0] tx, tx_oe, uart_rx;
	logic [7:0] hs_a, gopt, gopt_b, cfg, rx_out_byte;
	logic uart_ir_rx, infrared_tx, gp3_bit6_in, wake_event, rx_byte_ready, rx_out_valid;
	int err_count = 0, cmp_count = 0;
	umps_top i_umps_top (.clk(clk), .srst(srst), .clear_to_send_in_n(cts_n), .set_ready_in_n(dsr_n),
		.carrier_detect_in_n(dcd_n), .ring_indicator_in_n(ri_n), .serial_rx(serial_rx),
		.request_send_pin_in(rts_pin), .request_send_out_n(rts_n), .request_send_oe(rts_oe),
		.terminal_ready_pin_in(dtr_pin), .terminal_ready_out_n(dtr_n), .terminal_ready_oe(dtr_oe),
		.serial_tx_pin_in(tx_pin), .serial_tx(tx), .serial_tx_oe(tx_oe), .uart_rts(uart_rts),
		.uart_dtr(uart_dtr), .uart_tx(uart_tx), .uart_rx(uart_rx), .hs_status_a(hs_a),
		.hs_status_b(), .ir_mode(ir_mode), .infrared_rx(infrared_rx), .infrared_tx(infrared_tx),
		.uart_ir_tx(uart_ir_tx), .uart_ir_rx(uart_ir_rx), .gp3_bit7_out(gp3_bit7_out),
		.gp3_bit6_in(gp3_bit6_in), .consumer_ir_rx_n(consumer_ir_rx_n), .wake_enable(wake_enable),
		.wake_clear(wake_clear), .wake_event(wake_event), .rx_byte_valid(rx_byte_valid),
		.rx_byte_ready(rx_byte_ready), .rx_byte(rx_byte), .rx_out_valid(rx_out_valid),
		.rx_out_ready(rx_out_ready), .rx_out_byte(rx_out_byte), .global_option_reg(gopt),
		.global_option_reg_b(gopt_b), .cfg_port_addr(cfg));
	umps_modem i_umps_modem (.rts_n(rts_n), .rts_oe(rts_oe), .dtr_n(dtr_n), .dtr_oe(dtr_oe),
		.tx(tx), .tx_oe(tx_oe), .pull_up(pull_up), .state(state), .rts_pin(rts_pin),
		.dtr_pin(dtr_pin), .tx_pin(tx_pin), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n));
	// 25 MHz clock
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Reset with given straps, then wait out the settle count
	task automatic strap_reset(input logic [3:0] p);
		pull_up = p;
		srst = 1;
		cyc(6);
		srst = 0;
		cyc(8);
		pull_up = 0;
	endtask
	// Watchdog, far past the roughly 70 cycles the tests take
	initial begin
		#200000;
		err_count++;
		complete_run();
	end
	initial begin
		@(negedge clk);
		strap_reset(4'hF);
		chk(gopt, 8'h43);
		chk(gopt_b, 8'h40);
		chk(cfg, umps_pkg::CFG_PORT_HIGH);
		chk(8'(tx_oe), 8'h03);
		uart_rts = 2'h3;
		uart_dtr = 2'h2;
		uart_tx = 2'h1;
		cyc(3);
		chk(8'(rts_n), 8'h00);
		chk(8'(dtr_n), 8'h01);
		chk(8'(tx), 8'h01);
		chk(gopt, 8'h43);
		serial_rx = 2'h2;
		cyc(4);
		chk(8'(uart_rx), 8'h02);
		state = 4'hF;
		cyc(5);
		chk(hs_a, 8'hF0);
		state = 4'h0;
		cyc(5);
		chk(hs_a, 8'h00);
		ir_mode = 1;
		infrared_rx = 0;
		uart_ir_tx = 0;
		gp3_bit7_out = 1;
		cyc(3);
		chk({6'h0, uart_ir_rx, gp3_bit6_in, infrared_tx}, 8'h02);
		ir_mode = 0;
		cyc(3);
		chk({6'h0, uart_ir_rx, gp3_bit6_in, infrared_tx}, 8'h05);
		wake_enable = 1;
		consumer_ir_rx_n = 0;
		cyc(10);
		consumer_ir_rx_n = 1;
		cyc(3);
		chk(8'(wake_event), 8'h01);
		wake_clear = 1;
		cyc(2);
		wake_clear = 0;
		chk(8'(wake_event), 8'h00);
		// Fill two bytes with the reader stalled, then ready must be low
		for (int i = 0; i < 2; i++) begin
			rx_byte_valid = 1;
			rx_byte = 8'hA0 + 8'(i);
			cyc(1);
		end
		chk(8'(rx_byte_ready), 8'h00);
		rx_byte_valid = 0;
		for (int i = 0; i < 2; i++) begin
			chk({7'h0, rx_out_valid}, 8'h01);
			chk(rx_out_byte, 8'hA0 + 8'(i));
			rx_out_ready = 1;
			cyc(1);
			rx_out_ready = 0;
		end
		chk(8'(rx_out_valid), 8'h00);
		strap_reset(4'h0);
		chk(gopt, 8'h00);
		chk(cfg, umps_pkg::CFG_PORT_LOW);
		complete_run();
	end
endmodule
`default_nettype wire

// file: verilog/umps_pkg.sv
package umps_pkg;
	// Handshake status bit positions
	localparam int HS_CTS_BIT = 4;
	localparam int HS_DSR_BIT = 5;
	localparam int HS_RI_BIT = 6;
	localparam int HS_DCD_BIT = 7;
	// Strap destinations
	localparam int GOPT_PNP_BIT = 0;
	localparam int GOPT_ROM_BIT = 1;
	localparam int GOPT_CLK_BIT = 6;
	localparam int GOPTB_CFG_BIT = 6;
	// Values after reset
	localparam logic [7:0] GOPT_RESET = 8'h00;
	localparam logic [7:0] GOPTB_RESET = 8'h00;
	localparam logic [7:0] CFG_PORT_HIGH = 8'h4E;
	localparam logic [7:0] CFG_PORT_LOW = 8'h2E;
	// Wake filter length in cycles
	localparam logic [3:0] WAKE_COUNT = 4'h4;
	// Buffer depth
	localparam int BUF_DEPTH = 2;
endpackage

// file: verilog/umps_skid_buf.sv
`timescale 1ns/1ns
`default_nettype none
module umps_skid_buf (
	input wire logic clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data
);
	logic [7:0] mem [0:umps_pkg::BUF_DEPTH-1];
	logic [7:0] next_mem [0:umps_pkg::BUF_DEPTH-1];
	logic rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
	logic [1:0] count, next_count;
	logic do_wr, do_rd;

	// ----------------------------------------
	// Two-entry store, full blocks writer
	// ----------------------------------------
	always_comb begin
		in_ready = (count != 2'h2);
		out_valid = (count != 2'h0);
		out_data = mem[rd_ptr];
		do_wr = in_valid && in_ready;
		do_rd = out_valid && out_ready;
		next_mem = mem;
		if (do_wr) begin
			next_mem[wr_ptr] = in_data;
		end
		next_wr_ptr = wr_ptr ^ do_wr;
		next_rd_ptr = rd_ptr ^ do_rd;
		next_count = count + {1'b0, do_wr} - {1'b0, do_rd};
	end

	always_ff @(posedge clk) begin
		mem <= next_mem;
		if (srst) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count <= next_count;
		end
	end
endmodule
`default_nettype wire

// file: verilog/umps_top.sv
// Behaviour
// - Clear-to-send input level shows inverted as bit 4 of handshake status.
// - Each channel drives request-to-send low when ready to send.
// - Each channel drives terminal-ready low when ready to communicate.
// - Channel A request-to-send pin sampled at reset into option B bit 6.
// - Channel A terminal-ready pin sampled at reset into option bit 0.
// - Channel A serial output pin sampled at reset into option bit 1.
// - Channel B serial output pin sampled at reset into option bit 6.
// - Serial in received, serial out driven once strapping ends.
// - Infrared pins shared with port 3 bits 6 and 7 by mode.
// - Consumer infrared activity raises wake even in soft-off.
`timescale 1ns/1ns
`default_nettype none
module umps_top (
	input wire logic clk,
	input wire logic srst,
	// Modem inputs, channel A then B in bit 0 and 1
	input wire logic [1:0] clear_to_send_in_n,
	input wire logic [1:0] set_ready_in_n,
	input wire logic [1:0] carrier_detect_in_n,
	input wire logic [1:0] ring_indicator_in_n,
	input wire logic [1:0] serial_rx,
	// Modem outputs, pin level and enable
	input wire logic [1:0] request_send_pin_in,
	output logic [1:0] request_send_out_n,
	output logic [1:0] request_send_oe,
	input wire logic [1:0] terminal_ready_pin_in,
	output logic [1:0] terminal_ready_out_n,
	output logic [1:0] terminal_ready_oe,
	input wire logic [1:0] serial_tx_pin_in,
	output logic [1:0] serial_tx,
	output logic [1:0] serial_tx_oe,
	// UART core side
	input wire logic [1:0] uart_rts,
	input wire logic [1:0] uart_dtr,
	input wire logic [1:0] uart_tx,
	output logic [1:0] uart_rx,
	output logic [7:0] hs_status_a,
	output logic [7:0] hs_status_b,
	// Infrared and port 3 sharing
	input wire logic ir_mode,
	input wire logic infrared_rx,
	output logic infrared_tx,
	input wire logic uart_ir_tx,
	output logic uart_ir_rx,
	input wire logic gp3_bit7_out,
	output logic gp3_bit6_in,
	// Consumer infrared wake
	input wire logic consumer_ir_rx_n,
	input wire logic wake_enable,
	input wire logic wake_clear,
	output logic wake_event,
	// Received-bit byte stream into the buffer
	input wire logic rx_byte_valid,
	output logic rx_byte_ready,
	input wire logic [7:0] rx_byte,
	output logic rx_out_valid,
	input wire logic rx_out_ready,
	output logic [7:0] rx_out_byte,
	// Strap results
	output logic [7:0] global_option_reg,
	output logic [7:0] global_option_reg_b,
	output logic [7:0] cfg_port_addr
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int SW = 18;
	logic [SW-1:0] sync1, sync2, next_sync1, next_sync2;
	logic [1:0] cts_s, dsr_s, dcd_s, ri_s, rx_s, rts_pin_s, dtr_pin_s, tx_pin_s;
	logic infrared_rx_s, cir_s;

	// Pins are async to clk, two flops before use
	always_comb begin
		next_sync1 = {clear_to_send_in_n, set_ready_in_n, carrier_detect_in_n,
			ring_indicator_in_n, serial_rx, request_send_pin_in,
			terminal_ready_pin_in, serial_tx_pin_in, infrared_rx, consumer_ir_rx_n};
		next_sync2 = sync1;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sync1 <= {SW{1'b1}};
			sync2 <= {SW{1'b1}};
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
		end
	end

	assign {cts_s, dsr_s, dcd_s, ri_s, rx_s, rts_pin_s, dtr_pin_s, tx_pin_s,
		infrared_rx_s, cir_s} = sync2;

	// ----------------------------------------
	// Strap capture and pin roles
	// ----------------------------------------
	logic strap_done, next_strap_done;
	logic [7:0] next_gopt, next_goptb, next_cfg;

	function automatic logic [7:0] umps_set_bit(input logic [7:0] v, input int pos,
		input logic b);
		logic [7:0] r;
		r = v;
		r[pos[2:0]] = b;
		return r;
	endfunction

	// Capture once the settle count reaches 3 after reset release, then freeze
	always_comb begin
		next_strap_done = 1'b1;
		next_gopt = global_option_reg;
		next_goptb = global_option_reg_b;
		next_cfg = cfg_port_addr;
		if (!strap_done) begin
			next_gopt = umps_set_bit(umps_pkg::GOPT_RESET, umps_pkg::GOPT_PNP_BIT,
				dtr_pin_s[0]);
			next_gopt = umps_set_bit(next_gopt, umps_pkg::GOPT_ROM_BIT, tx_pin_s[0]);
			next_gopt = umps_set_bit(next_gopt, umps_pkg::GOPT_CLK_BIT, tx_pin_s[1]);
			next_goptb = umps_set_bit(umps_pkg::GOPTB_RESET, umps_pkg::GOPTB_CFG_BIT,
				rts_pin_s[0]);
			next_cfg = rts_pin_s[0] ? umps_pkg::CFG_PORT_HIGH : umps_pkg::CFG_PORT_LOW;
		end
	end

	// Sync chain is only two deep; straps need the settled pull level
	logic [1:0] settle, next_settle;
	always_comb begin
		next_settle = (settle == 2'h3) ? settle : settle + 2'h1;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			settle <= 2'h0;
			strap_done <= 1'b0;
			global_option_reg <= umps_pkg::GOPT_RESET;
			global_option_reg_b <= umps_pkg::GOPTB_RESET;
			cfg_port_addr <= umps_pkg::CFG_PORT_LOW;
		end else begin
			settle <= next_settle;
			if (settle == 2'h3) begin
				strap_done <= next_strap_done;
				global_option_reg <= next_gopt;
				global_option_reg_b <= next_goptb;
				cfg_port_addr <= next_cfg;
			end
		end
	end

	// ----------------------------------------
	// Modem outputs and status
	// ----------------------------------------
	logic [1:0] next_rts, next_dtr, next_tx, next_oe, next_urx;
	logic [7:0] next_hsa, next_hsb;
	logic next_infrared_tx, next_uirrx, next_gp6;

	function automatic logic [7:0] umps_hs(input logic cts, input logic dsr,
		input logic ri, input logic dcd);
		logic [7:0] r;
		r = 8'h00;
		r[umps_pkg::HS_CTS_BIT] = cts;
		r[umps_pkg::HS_DSR_BIT] = dsr;
		r[umps_pkg::HS_RI_BIT] = ri;
		r[umps_pkg::HS_DCD_BIT] = dcd;
		return r;
	endfunction

	always_comb begin
		// Pins float for the pull straps until captured
		next_oe = {2{strap_done}};
		next_rts = ~uart_rts;
		next_dtr = ~uart_dtr;
		next_tx = uart_tx;
		next_urx = rx_s;
		next_hsa = umps_hs(~cts_s[0], ~dsr_s[0], ~ri_s[0], ~dcd_s[0]);
		next_hsb = umps_hs(~cts_s[1], ~dsr_s[1], ~ri_s[1], ~dcd_s[1]);
		next_infrared_tx = ir_mode ? uart_ir_tx : gp3_bit7_out;
		next_uirrx = ir_mode ? infrared_rx_s : 1'b1;
		next_gp6 = ir_mode ? 1'b1 : infrared_rx_s;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			request_send_out_n <= 2'h3;
			terminal_ready_out_n <= 2'h3;
			serial_tx <= 2'h3;
			request_send_oe <= 2'h0;
			terminal_ready_oe <= 2'h0;
			serial_tx_oe <= 2'h0;
			uart_rx <= 2'h3;
			hs_status_a <= 8'h00;
			hs_status_b <= 8'h00;
			infrared_tx <= 1'b0;
			uart_ir_rx <= 1'b1;
			gp3_bit6_in <= 1'b1;
		end else begin
			request_send_out_n <= next_rts;
			terminal_ready_out_n <= next_dtr;
			serial_tx <= next_tx;
			request_send_oe <= next_oe;
			terminal_ready_oe <= next_oe;
			serial_tx_oe <= next_oe;
			uart_rx <= next_urx;
			hs_status_a <= next_hsa;
			hs_status_b <= next_hsb;
			infrared_tx <= next_infrared_tx;
			uart_ir_rx <= next_uirrx;
			gp3_bit6_in <= next_gp6;
		end
	end

	// ----------------------------------------
	// Consumer infrared wake
	// ----------------------------------------
	logic [3:0] low_cnt, next_low_cnt;
	logic next_wake;

	// Short filter rejects glitches; set beats clear
	always_comb begin
		next_low_cnt = cir_s ? 4'h0 :
			(low_cnt == umps_pkg::WAKE_COUNT) ? low_cnt : low_cnt + 4'h1;
		next_wake = wake_event && !wake_clear;
		if (wake_enable && low_cnt == umps_pkg::WAKE_COUNT - 4'h1 && !cir_s) begin
			next_wake = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			low_cnt <= 4'h0;
			wake_event <= 1'b0;
		end else begin
			low_cnt <= next_low_cnt;
			wake_event <= next_wake;
		end
	end

	// ----------------------------------------
	// Receive byte buffer
	// ----------------------------------------
	logic buf_in_ready, buf_out_valid;
	logic [7:0] buf_out_data;

	umps_skid_buf u_buf (
		.clk(clk),
		.srst(srst),
		.in_valid(rx_byte_valid),
		.in_ready(buf_in_ready),
		.in_data(rx_byte),
		.out_valid(buf_out_valid),
		.out_ready(rx_out_ready),
		.out_data(buf_out_data)
	);

	// Outputs mirror the buffer combinationally through flop-free path
	always_comb begin
		rx_byte_ready = buf_in_ready;
		rx_out_valid = buf_out_valid;
		rx_out_byte = buf_out_data;
	end
endmodule
`default_nettype wire
